// file: bench/asgor_regs_props.sv
// Checker of bus timing and output routing for the AFE register bank
`default_nettype none
module asgor_regs_props (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic sample_pulse_input,
	input wire logic [3:0] adc_data_nibble,
	input wire logic video_sample_clock,
	input wire logic adc_clock,
	input wire logic reset_sample_clock,
	input wire logic [3:0] output_nibble,
	input wire logic timing_sync_pulse
);
	logic det_q, pol_q, test_clock_out_select_q, pin_q, wr_ok, hit;
	logic [2:0] dly_q, up_q;
	logic [7:0] ev_q;
	logic [3:0] age_q;
	// Held off until the design's own synchronised reset has let go
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n || !up_q[2]);
	assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
	assign hit = pol_q ? sample_pulse_input && !pin_q : !sample_pulse_input && pin_q;
	// Shadow of the mode bits; age counts calm cycles after a config change
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{pol_q, dly_q, det_q, test_clock_out_select_q} <= '0;
			age_q <= '0;
		end
		else if (wr_ok && avs_address == asgor_pkg::ADDR_SAMPLE_PULSE_CONFIG)
		begin
			{pol_q, dly_q, det_q} <= avs_writedata[4:0];
			age_q <= '0;
		end
		else
		begin
			if (wr_ok && avs_address == asgor_pkg::ADDR_TEST_OUTPUT_SELECT)
				test_clock_out_select_q <= avs_writedata[0];
			age_q <= age_q + {3'h0, age_q != 4'hf};
		end
	end
	// Edge history, so each delay setting has its expected slot
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			{pin_q, ev_q, up_q} <= '0;
		else
		begin
			pin_q <= sample_pulse_input;
			ev_q <= {ev_q[6:0], hit};
			up_q <= {up_q[1:0], 1'b1};
		end
	end
	sequence s_grant;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	property p_wait;
		$rose(avs_read || avs_write) |-> avs_waitrequest ##1 s_grant;
	endproperty
	property p_idle;
		!avs_read && !avs_write |=> avs_waitrequest;
	endproperty
	property p_upper;
		avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000;
	endproperty
	property p_bcast;
		avs_read && !avs_waitrequest && (avs_address == asgor_pkg::ADDR_ALL_OFFSET ||
			avs_address == asgor_pkg::ADDR_ALL_GAIN) |-> avs_readdata == 32'h0;
	endproperty
	property p_pass;
		!det_q |=> timing_sync_pulse == $past(sample_pulse_input);
	endproperty
	property p_detect;
		det_q && age_q > 4'h9 |-> timing_sync_pulse == ev_q[dly_q];
	endproperty
	property p_nib_data;
		!test_clock_out_select_q |=> output_nibble == $past(adc_data_nibble);
	endproperty
	property p_nib_test;
		test_clock_out_select_q |=> output_nibble == {timing_sync_pulse, $past(video_sample_clock),
			$past(adc_clock), $past(reset_sample_clock)};
	endproperty
	a_wait: assert property (p_wait) else $error("waitrequest not one cycle");
	a_idle: assert property (p_idle) else $error("waitrequest low while idle");
	a_upper: assert property (p_upper) else $error("readdata upper bits set");
	a_bcast: assert property (p_bcast) else $error("broadcast read not zero");
	a_pass: assert property (p_pass) else $error("pass-through level wrong");
	a_detect: assert property (p_detect) else $error("detected pulse slot wrong");
	a_nib_data: assert property (p_nib_data) else $error("nibble not ADC data");
	a_nib_test: assert property (p_nib_test) else $error("nibble not strobes");
endmodule
`default_nettype wire

// file: bench/asgor_regs_tb_top.sv
// Top testbench for the AFE register bank
`default_nettype none
module asgor_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic fire = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h0;
	logic [31:0] avs_readdata, rd_q;
	logic avs_waitrequest, sample_pulse_input, video_sample_clock, adc_clock;
	logic reset_sample_clock, timing_sync_pulse;
	logic [3:0] adc_data_nibble, output_nibble;
	logic [7:0] applied_offset_code, applied_gain_code;
	int miscompares = 0;
	int checked = 0;
	int n, n3, k;
	asgor_regs uut (.clock, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .sample_pulse_input,
		.adc_data_nibble, .video_sample_clock, .adc_clock, .reset_sample_clock,
		.output_nibble, .timing_sync_pulse, .applied_offset_code, .applied_gain_code);
	asgor_scan_ctrl u_far (.clock, .rst_n, .fire, .sample_pulse_input, .adc_data_nibble,
		.video_sample_clock, .adc_clock, .reset_sample_clock);
	// ------
	// Bus tasks
	// ------
	initial
	begin
		forever #25 clock = ~clock;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
		input logic [3:0] be);
		int i;
		@(posedge clock);
		avs_address <= a;
		avs_read <= !w;
		avs_write <= w;
		avs_writedata <= {24'h0, d};
		avs_byteenable <= be;
		i = 0;
		do
		begin
			@(posedge clock);
			i++;
		end
		while (avs_waitrequest !== 1'b0 && i < 16);
		chk({31'h0, avs_waitrequest}, 32'h0);
		rd_q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] exp);
		bus(1'b0, a, 8'h00, 4'hf);
		chk(rd_q, exp);
	endtask
	// Fires one sample pulse and counts output highs over the window
	task automatic pulse;
		@(posedge clock);
		fire <= 1'b1;
		@(posedge clock);
		fire <= 1'b0;
		n = 0;
		n3 = 0;
		repeat (16)
		begin
			@(negedge clock);
			n += int'(timing_sync_pulse === 1'b1);
			n3 += int'(output_nibble[3] === 1'b1);
		end
	endtask
	task automatic conclude;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ------
	// Tests
	// ------
	initial
	begin
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		repeat (2) @(posedge clock);
		for (int a = 0; a < 13; a++)
			rd(6'(a * 4), (a inside {2, 3, 4, 11}) ? 32'h80 : 32'h0);
		$display("test reset values done");
		for (int c = 0; c < 3; c++)
		begin
			bus(1'b1, asgor_pkg::ADDR_RED_OFFSET + 6'(c * 4), 8'(8'h11 * (c + 1)), 4'h1);
			bus(1'b1, asgor_pkg::ADDR_RED_GAIN + 6'(c * 4), 8'(8'hc1 + c), 4'h1);
		end
		for (int c = 0; c < 4; c++)
		begin
			k = (c == 3) ? 0 : c;
			bus(1'b1, asgor_pkg::ADDR_COLOUR_SELECT, 8'(c), 4'h1);
			rd(asgor_pkg::ADDR_APPLIED_CODES, 32'(((8'hc1 + k) << 8) | (8'h11 * (k + 1))));
			chk({16'h0, applied_gain_code, applied_offset_code}, rd_q);
		end
		$display("test colour select done");
		bus(1'b1, asgor_pkg::ADDR_ALL_OFFSET, 8'h5a, 4'h1);
		bus(1'b1, asgor_pkg::ADDR_ALL_GAIN, 8'hc3, 4'h1);
		bus(1'b1, asgor_pkg::ADDR_RED_OFFSET, 8'ha5, 4'h0);
		bus(1'b1, 6'h30, 8'hff, 4'h1);
		rd(6'h30, 32'h0);
		for (int c = 0; c < 3; c++)
		begin
			rd(asgor_pkg::ADDR_RED_OFFSET + 6'(c * 4), 32'h5a);
			rd(asgor_pkg::ADDR_RED_GAIN + 6'(c * 4), 32'hc3);
		end
		rd(asgor_pkg::ADDR_ALL_GAIN, 32'h0);
		$display("test broadcast done");
		for (int m = 0; m < 16; m++)
		begin
			bus(1'b1, asgor_pkg::ADDR_SAMPLE_PULSE_CONFIG, {3'h0, 4'(m), 1'b1}, 4'h1);
			pulse();
			chk(n, 1);
		end
		bus(1'b1, asgor_pkg::ADDR_SAMPLE_PULSE_CONFIG, 8'h00, 4'h1);
		bus(1'b1, asgor_pkg::ADDR_TEST_OUTPUT_SELECT, 8'h01, 4'h1);
		pulse();
		chk(n, 3);
		chk(n3, 3);
		bus(1'b1, asgor_pkg::ADDR_TEST_OUTPUT_SELECT, 8'h00, 4'h1);
		repeat (20) @(posedge clock);
		$display("test sample pulse done");
		conclude();
	end
	initial
	begin
		#200000;
		miscompares++;
		conclude();
	end
endmodule
bind asgor_regs asgor_regs_props u_props (.clock, .rst_n, .avs_address, .avs_read,
	.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
	.sample_pulse_input, .adc_data_nibble, .video_sample_clock, .adc_clock,
	.reset_sample_clock, .output_nibble, .timing_sync_pulse);
`default_nettype wire

// file: bench/asgor_scan_ctrl.sv
// Scanner controller model: sample pulses and free-running timing levels
`default_nettype none
module asgor_scan_ctrl (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic fire,
	output logic sample_pulse_input,
	output logic [3:0] adc_data_nibble,
	output logic video_sample_clock,
	output logic adc_clock,
	output logic reset_sample_clock
);
	logic [5:0] cnt_q;
	logic [1:0] hi_q;
	// Three-cycle pulse so both edges are well apart
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			{cnt_q, hi_q} <= '0;
		else
		begin
			cnt_q <= cnt_q + 6'h01;
			hi_q <= fire ? 2'h3 : hi_q - {1'b0, hi_q != 2'h0};
		end
	end
	assign sample_pulse_input = hi_q != 2'h0;
	assign adc_data_nibble = cnt_q[5:2];
	assign video_sample_clock = cnt_q[1];
	assign adc_clock = cnt_q[0];
	assign reset_sample_clock = cnt_q[2];
endmodule
`default_nettype wire

// file: core/asgor_colour_bank.sv
// Three colour code registers with broadcast load and colour-selected output
`default_nettype none
module asgor_colour_bank #(
	parameter logic [7:0] RESET_VAL = 8'h00
)
(
	input wire logic clock,
	input wire logic rst_sync_n,
	input wire logic [2:0] wr_one,
	input wire logic wr_all,
	input wire logic [7:0] wdata,
	input wire logic [1:0] colour_select,
	output logic [23:0] codes,
	output logic [7:0] applied
);
	logic [7:0] code_q [3];

	// Per-colour storage; broadcast has no storage, it only loads all three
	for (genvar i = 0; i < 3; i++)
	begin : g_col
		always_ff @(posedge clock or negedge rst_sync_n)
		begin
			if (!rst_sync_n)
				code_q[i] <= RESET_VAL;
			else if (wr_all || wr_one[i])
				code_q[i] <= wdata;
		end
		assign codes[8*i +: 8] = code_q[i];
	end

	// Colour selection; reserved code 11 falls back to red
	always_comb
	begin
		unique case (colour_select)
			asgor_pkg::COL_GREEN: applied = code_q[1];
			asgor_pkg::COL_BLUE: applied = code_q[2];
			default: applied = code_q[0];
		endcase
	end
endmodule
`default_nettype wire

// file: core/asgor_pkg.sv
// Package of register map, field layout and reset values for the AFE control bank
`default_nettype none
package asgor_pkg;
	// Register byte addresses (one aligned word each)
	localparam logic [5:0] ADDR_SAMPLE_PULSE_CONFIG = 6'h00;
	localparam logic [5:0] ADDR_TEST_OUTPUT_SELECT = 6'h04;
	localparam logic [5:0] ADDR_RED_OFFSET = 6'h08;
	localparam logic [5:0] ADDR_GREEN_OFFSET = 6'h0c;
	localparam logic [5:0] ADDR_BLUE_OFFSET = 6'h10;
	localparam logic [5:0] ADDR_ALL_OFFSET = 6'h14;
	localparam logic [5:0] ADDR_RED_GAIN = 6'h18;
	localparam logic [5:0] ADDR_GREEN_GAIN = 6'h1c;
	localparam logic [5:0] ADDR_BLUE_GAIN = 6'h20;
	localparam logic [5:0] ADDR_ALL_GAIN = 6'h24;
	localparam logic [5:0] ADDR_COLOUR_SELECT = 6'h28;
	localparam logic [5:0] ADDR_APPLIED_CODES = 6'h2c;
	// Field positions
	localparam int DET_EN_BIT = 0;
	localparam int DELAY_LSB = 1;
	localparam int DELAY_MSB = 3;
	localparam int POL_BIT = 4;
	localparam int TEST_CLOCK_OUT_SELECT_BIT = 0;
	// Reset values
	localparam logic [7:0] SPC_RESET = 8'h00;
	localparam logic [7:0] TOS_RESET = 8'h00;
	localparam logic [7:0] OFFSET_RESET = 8'h80;
	localparam logic [7:0] GAIN_RESET = 8'h00;
	localparam logic [1:0] COLOUR_RESET = 2'h0;
	// Colour select encodings
	localparam logic [1:0] COL_RED = 2'h0;
	localparam logic [1:0] COL_GREEN = 2'h1;
	localparam logic [1:0] COL_BLUE = 2'h2;
	// Unmapped reads return this
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage
`default_nettype wire

// file: core/asgor_pulse_detect.sv
// Sample-pulse conditioner: pass-through or edge detect with programmable delay
`default_nettype none
module asgor_pulse_detect #(
	parameter int DELAY_W = 3
)
(
	input wire logic clock,
	input wire logic rst_sync_n,
	input wire logic sample_pulse_input,
	input wire logic pulse_detect_enable,
	input wire logic edge_polarity_select,
	input wire logic [DELAY_W-1:0] pulse_delay_count,
	output logic internal_sync_pulse
);
	// The shift line holds 2**DELAY_W taps, so very wide fields are refused
	if (DELAY_W < 1 || DELAY_W > 8)
	begin : g_bad_width
		$error("DELAY_W out of range");
	end

	logic prev_q;
	logic [(1<<DELAY_W)-1:0] pipe_q;
	logic hit;

	// Previous pin level for edge detection
	always_ff @(posedge clock or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			prev_q <= 1'b0;
		else
			prev_q <= sample_pulse_input;
	end

	// Chosen edge: rising when polarity is 1, falling otherwise
	assign hit = edge_polarity_select ? (sample_pulse_input & ~prev_q)
		: (~sample_pulse_input & prev_q);

	// Shift line; tap N gives a delay of N+1 clock periods after the edge
	always_ff @(posedge clock or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			pipe_q <= '0;
		else
			pipe_q <= {pipe_q[(1<<DELAY_W)-2:0], hit};
	end

	// Mode select; delay N reads tap N-1, delay 0 takes the detect cycle itself
	always_comb
	begin
		if (!pulse_detect_enable)
			internal_sync_pulse = sample_pulse_input;
		else if (pulse_delay_count == '0)
			internal_sync_pulse = hit;
		else
			internal_sync_pulse = pipe_q[pulse_delay_count - 1'b1];
	end
endmodule
`default_nettype wire

// file: core/asgor_regs.sv
// Top: Avalon-MM register bank for sample-pulse setup, test output and offset/gain codes
`default_nettype none
// Functional notes
// - Detect off: pin level passes straight through
// - Detect on: internal pulse built from pin
// - Internal pulse delayed by delay field periods
// - Polarity bit picks rising or falling edge
// - Test select 0: nibble carries ADC data
// - Three offset codes, reset 0x80, colour-selected
// - Broadcast offset write loads all three
// - Three gain codes, reset zero, colour-selected
// - Broadcast gain write loads all three
// - Colour select 00 red, 01 green, 10 blue
module asgor_regs (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic sample_pulse_input,
	input wire logic [3:0] adc_data_nibble,
	input wire logic video_sample_clock,
	input wire logic adc_clock,
	input wire logic reset_sample_clock,
	output logic [3:0] output_nibble,
	output logic timing_sync_pulse,
	output logic [7:0] applied_offset_code,
	output logic [7:0] applied_gain_code
);
	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rst_s1_q;
	logic rst_sync_n;

	// Two-stage release keeps deassertion synchronous to the clock
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_s1_q <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_sync_n <= rst_s1_q;
		end
	end

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	logic ack_q;
	logic wr_take;
	logic rd_take;
	logic lane0;
	logic [7:0] spc_q;
	logic [7:0] tos_q;
	logic [1:0] colour_select_q;
	logic [23:0] offset_codes;
	logic [23:0] gain_codes;
	logic [7:0] applied_offset;
	logic [7:0] applied_gain;
	logic internal_sync_pulse;

	// Waitrequest drops one cycle after a request arrives, so every access takes two cycles
	always_ff @(posedge clock or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			ack_q <= 1'b0;
		else
			ack_q <= (avs_read || avs_write) && !ack_q;
	end

	assign avs_waitrequest = !ack_q;
	assign wr_take = avs_write && ack_q;
	assign rd_take = avs_read && ack_q;
	assign lane0 = avs_byteenable[0];

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	// Config register stores all eight bits; software keeps 7:5 at zero
	always_ff @(posedge clock or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			spc_q <= asgor_pkg::SPC_RESET;
		else if (wr_take && lane0 && avs_address == asgor_pkg::ADDR_SAMPLE_PULSE_CONFIG)
			spc_q <= avs_writedata[7:0];
	end

	// Test output select
	always_ff @(posedge clock or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			tos_q <= asgor_pkg::TOS_RESET;
		else if (wr_take && lane0 && avs_address == asgor_pkg::ADDR_TEST_OUTPUT_SELECT)
			tos_q <= avs_writedata[7:0];
	end

	// Colour select lives in its own register here
	always_ff @(posedge clock or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			colour_select_q <= asgor_pkg::COLOUR_RESET;
		else if (wr_take && lane0 && avs_address == asgor_pkg::ADDR_COLOUR_SELECT)
			colour_select_q <= avs_writedata[1:0];
	end

	// ----------------------------------------
	// Offset and gain banks
	// ----------------------------------------
	asgor_colour_bank #(
		.RESET_VAL(asgor_pkg::OFFSET_RESET)
	) u_offset (
		.clock(clock),
		.rst_sync_n(rst_sync_n),
		.wr_one({wr_take && lane0 && avs_address == asgor_pkg::ADDR_BLUE_OFFSET,
			wr_take && lane0 && avs_address == asgor_pkg::ADDR_GREEN_OFFSET,
			wr_take && lane0 && avs_address == asgor_pkg::ADDR_RED_OFFSET}),
		.wr_all(wr_take && lane0 && avs_address == asgor_pkg::ADDR_ALL_OFFSET),
		.wdata(avs_writedata[7:0]),
		.colour_select(colour_select_q),
		.codes(offset_codes),
		.applied(applied_offset)
	);

	asgor_colour_bank #(
		.RESET_VAL(asgor_pkg::GAIN_RESET)
	) u_gain (
		.clock(clock),
		.rst_sync_n(rst_sync_n),
		.wr_one({wr_take && lane0 && avs_address == asgor_pkg::ADDR_BLUE_GAIN,
			wr_take && lane0 && avs_address == asgor_pkg::ADDR_GREEN_GAIN,
			wr_take && lane0 && avs_address == asgor_pkg::ADDR_RED_GAIN}),
		.wr_all(wr_take && lane0 && avs_address == asgor_pkg::ADDR_ALL_GAIN),
		.wdata(avs_writedata[7:0]),
		.colour_select(colour_select_q),
		.codes(gain_codes),
		.applied(applied_gain)
	);

	// Applied codes are registered so outputs come from flops
	// Gain code maps to 0.78 + code * 7.57 / 255 in the analogue stage
	always_ff @(posedge clock or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			applied_offset_code <= asgor_pkg::OFFSET_RESET;
			applied_gain_code <= asgor_pkg::GAIN_RESET;
		end
		else
		begin
			applied_offset_code <= applied_offset;
			applied_gain_code <= applied_gain;
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Broadcast locations read zero: they hold nothing
	always_ff @(posedge clock or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			avs_readdata <= asgor_pkg::UNMAPPED_READ;
		else if ((avs_read || avs_write) && !ack_q)
		begin
			unique case (avs_address)
				asgor_pkg::ADDR_SAMPLE_PULSE_CONFIG: avs_readdata <= {24'h000000, spc_q};
				asgor_pkg::ADDR_TEST_OUTPUT_SELECT: avs_readdata <= {24'h000000, tos_q};
				asgor_pkg::ADDR_RED_OFFSET: avs_readdata <= {24'h000000, offset_codes[7:0]};
				asgor_pkg::ADDR_GREEN_OFFSET: avs_readdata <= {24'h000000, offset_codes[15:8]};
				asgor_pkg::ADDR_BLUE_OFFSET: avs_readdata <= {24'h000000, offset_codes[23:16]};
				asgor_pkg::ADDR_RED_GAIN: avs_readdata <= {24'h000000, gain_codes[7:0]};
				asgor_pkg::ADDR_GREEN_GAIN: avs_readdata <= {24'h000000, gain_codes[15:8]};
				asgor_pkg::ADDR_BLUE_GAIN: avs_readdata <= {24'h000000, gain_codes[23:16]};
				asgor_pkg::ADDR_COLOUR_SELECT: avs_readdata <= {30'h00000000, colour_select_q};
				asgor_pkg::ADDR_APPLIED_CODES:
					avs_readdata <= {16'h0000, applied_gain, applied_offset};
				default: avs_readdata <= asgor_pkg::UNMAPPED_READ;
			endcase
		end
	end

	// ----------------------------------------
	// Sample-pulse conditioning
	// ----------------------------------------
	asgor_pulse_detect #(
		.DELAY_W(3)
	) u_detect (
		.clock(clock),
		.rst_sync_n(rst_sync_n),
		.sample_pulse_input(sample_pulse_input),
		.pulse_detect_enable(spc_q[asgor_pkg::DET_EN_BIT]),
		.edge_polarity_select(spc_q[asgor_pkg::POL_BIT]),
		.pulse_delay_count(spc_q[asgor_pkg::DELAY_MSB:asgor_pkg::DELAY_LSB]),
		.internal_sync_pulse(internal_sync_pulse)
	);

	// Timing pulse is registered; costs one cycle but keeps the output glitch free
	always_ff @(posedge clock or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			timing_sync_pulse <= 1'b0;
		else
			timing_sync_pulse <= internal_sync_pulse;
	end

	// ----------------------------------------
	// Output nibble mux
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			output_nibble <= 4'h0;
		else if (tos_q[asgor_pkg::TEST_CLOCK_OUT_SELECT_BIT])
			output_nibble <= {internal_sync_pulse, video_sample_clock,
				adc_clock, reset_sample_clock};
		else
			output_nibble <= adc_data_nibble;
	end
endmodule
`default_nettype wire
